// file: rtl/proximity_threshold_interrupt.sv
// Threshold interrupt logic of a proximity and ambient light sensor, AHB-Lite slave.
// Assumes measurement results arrive as one-cycle strobes on hclk.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Interrupt when selected result rises above upper threshold, after enable and hits.
// RULE2 - Interrupt only after programmed count of consecutive out-of-range results.
// RULE3 - Interrupt when selected result falls below lower threshold for required count.
// RULE4 - Separate sticky low and high threshold flags, readable by host.
// RULE5 - No comparison or interrupt while threshold function is disabled. Flags set before disabling still drive irq here.
// RULE6 - Configuration selects proximity or ambient results for comparison.
// RULE7 - Host clears status after servicing and may reprogram thresholds.
// RULE8 - Host may park upper threshold at full scale to disable it.
// RULE9 - Host sets lower threshold between offset and present count.
// RULE10 - Host waits a 1 to 10000 ms delay between on-demand requests.
// RULE11 - Host drives emitter selects; internal high with external low is forbidden.
// RULE12 - Thresholds and comparison are 16 bits wide like the results.
module proximity_threshold_interrupt
  import prox_thresh_pkg::*;
#(
  parameter int HITS_W = 8
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic prox_valid, // New proximity result strobe
  input wire logic [15:0] prox_result, // Proximity result
  input wire logic als_valid, // New ambient result strobe
  input wire logic [15:0] als_result, // Ambient result
  output logic irq // Level interrupt
);

  // ==========================================================
  // Elaboration checks
  initial begin
    if (HITS_W != `CTRL_HITS_W) begin
      $error("HITS_W must match the control field width");
    end
    if (HITS_W < 1) begin
      $error("HITS_W must be at least one");
    end
  end

  // ==========================================================
  // Register state
  logic [31:0] ctrl_q;
  result_t hi_q;
  result_t lo_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  result_t last_q;
  logic [HITS_W-1:0] hi_cnt_q;
  logic [HITS_W-1:0] lo_cnt_q;

  // ==========================================================
  // Bus slave, address phase capture
  logic take;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;

  // Only a NONSEQ or SEQ transfer with the bus ready opens a data phase
  assign take = hsel && hready && htrans[1];

  // Zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= take && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
    end else if (take) begin
      addr_q <= haddr[7:0];
    end
  end

  // ==========================================================
  // Data phase decode
  logic wr_ctrl;
  logic wr_hi;
  logic wr_lo;
  logic wr_mask;
  logic status_rd;

  assign wr_ctrl = wr_pend_q && (addr_q == `OFS_CTRL);
  assign wr_hi = wr_pend_q && (addr_q == `OFS_HI_THRESH);
  assign wr_lo = wr_pend_q && (addr_q == `OFS_LO_THRESH);
  assign wr_mask = wr_pend_q && (addr_q == `OFS_MASK);

  // Read clears status at the end of the data phase that returns it
  assign status_rd = rd_pend_q && (addr_q == `OFS_STATUS);

  // ==========================================================
  // Read data
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_q) begin
      unique case (addr_q)
        `OFS_CTRL: hrdata = ctrl_q;
        `OFS_HI_THRESH: hrdata = {16'h0000, hi_q};
        `OFS_LO_THRESH: hrdata = {16'h0000, lo_q};
        `OFS_STATUS: hrdata = {30'h0, status_q};
        `OFS_MASK: hrdata = {30'h0, mask_q};
        `OFS_LAST: hrdata = {16'h0000, last_q};
        `OFS_COUNT: hrdata = {16'h0000, hi_cnt_q, lo_cnt_q};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  // Unused control bits stay zero so a read returns only live fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= 32'h0000_0000;
      ctrl_q[`CTRL_EN_BIT] <= hwdata[`CTRL_EN_BIT]; // [RULE5]
      ctrl_q[`CTRL_SEL_BIT] <= hwdata[`CTRL_SEL_BIT]; // [RULE6]
      ctrl_q[`CTRL_HITS_LSB +: HITS_W] <= hwdata[`CTRL_HITS_LSB +: HITS_W]; // [RULE2]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= `HI_RESET;
    end else if (wr_hi) begin
      hi_q <= hwdata[15:0]; // [RULE12]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_q <= `LO_RESET;
    end else if (wr_lo) begin
      lo_q <= hwdata[15:0]; // [RULE12]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= hwdata[1:0];
    end
  end

  // ==========================================================
  // Result selection and comparison
  logic enable;
  logic [HITS_W-1:0] hits_field;
  logic [HITS_W-1:0] hits_need;
  logic sample_valid;
  result_t sample;
  logic above;
  logic below;

  assign enable = ctrl_q[`CTRL_EN_BIT];
  assign hits_field = ctrl_q[`CTRL_HITS_LSB +: HITS_W];

  // A programmed count of zero behaves as a single hit
  assign hits_need = (hits_field == '0) ? HITS_W'(1) : hits_field; // [RULE2]

  always_comb begin
    if (source_e'(ctrl_q[`CTRL_SEL_BIT]) == SRC_AMBIENT) begin // [RULE6]
      sample_valid = als_valid;
      sample = als_result;
    end else begin
      sample_valid = prox_valid;
      sample = prox_result;
    end
  end

  assign above = sample > hi_q; // [RULE1] [RULE12]
  assign below = sample < lo_q; // [RULE3] [RULE12]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_q <= 16'h0000;
    end else if (sample_valid) begin
      last_q <= sample;
    end
  end

  // ==========================================================
  // Consecutive hit counters
  logic hi_hit;
  logic lo_hit;
  logic hi_event;
  logic lo_event;
  logic [HITS_W-1:0] hi_next;
  logic [HITS_W-1:0] lo_next;

  // Counters saturate so a long excursion cannot wrap and fire again
  assign hi_next = (hi_cnt_q == '1) ? hi_cnt_q : hi_cnt_q + 1'b1;
  assign lo_next = (lo_cnt_q == '1) ? lo_cnt_q : lo_cnt_q + 1'b1;

  assign hi_hit = enable && sample_valid && above; // [RULE1] [RULE5]
  assign lo_hit = enable && sample_valid && below; // [RULE3] [RULE5]

  // Fires once, on the sample that brings the run to the needed length
  assign hi_event = hi_hit && (hi_next == hits_need) && (hi_cnt_q != hits_need); // [RULE2]
  assign lo_event = lo_hit && (lo_next == hits_need) && (lo_cnt_q != hits_need); // [RULE2]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt_q <= '0;
    end else if (!enable) begin // [RULE5]
      hi_cnt_q <= '0;
    end else if (sample_valid) begin
      hi_cnt_q <= above ? hi_next : '0; // [RULE2]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_cnt_q <= '0;
    end else if (!enable) begin // [RULE5]
      lo_cnt_q <= '0;
    end else if (sample_valid) begin
      lo_cnt_q <= below ? lo_next : '0; // [RULE2]
    end
  end

  // ==========================================================
  // Sticky status flags
  logic hi_flag_d;
  logic lo_flag_d;
  logic high_threshold_flag;
  logic low_threshold_flag;

  // Set wins over the read clear, so an event in the read's data phase survives
  assign hi_flag_d = hi_event || (status_q[`ST_HI_BIT] && !status_rd);
  assign lo_flag_d = lo_event || (status_q[`ST_LO_BIT] && !status_rd);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[`ST_HI_BIT] <= 1'b0;
    end else begin
      status_q[`ST_HI_BIT] <= hi_flag_d; // [RULE4]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[`ST_LO_BIT] <= 1'b0;
    end else begin
      status_q[`ST_LO_BIT] <= lo_flag_d; // [RULE4]
    end
  end

  assign high_threshold_flag = status_q[`ST_HI_BIT];
  assign low_threshold_flag = status_q[`ST_LO_BIT];

  // ==========================================================
  // Interrupt output
  // Level output: stays high until every unmasked flag is read clear
  assign irq = (high_threshold_flag && mask_q[`ST_HI_BIT])
               || (low_threshold_flag && mask_q[`ST_LO_BIT]); // [RULE4]

endmodule // proximity_threshold_interrupt

// file: rtl/prox_thresh_defs.svh
// Register offsets, field positions and reset values of the threshold interrupt block.
// Assumes inclusion by bare name from the package; the block uses the macros without including the file.
`ifndef PROX_THRESH_DEFS_SVH
`define PROX_THRESH_DEFS_SVH

`define OFS_CTRL       8'h00
`define OFS_HI_THRESH  8'h04
`define OFS_LO_THRESH  8'h08
`define OFS_STATUS     8'h0c
`define OFS_MASK       8'h10
`define OFS_LAST       8'h14
`define OFS_COUNT      8'h18

`define CTRL_EN_BIT    0
`define CTRL_SEL_BIT   1
`define CTRL_HITS_LSB  4
`define CTRL_HITS_W    8

`define ST_HI_BIT      0
`define ST_LO_BIT      1

`define CTRL_RESET     32'h0000_0010
`define HI_RESET       16'hffff
`define LO_RESET       16'h0000
`define MASK_RESET     2'h3

`endif

// file: rtl/prox_thresh_pkg.sv
// Types shared by the threshold interrupt block.
// Assumes prox_thresh_defs.svh is on the include path.
package prox_thresh_pkg;
  `include "prox_thresh_defs.svh"
  typedef logic [15:0] result_t;
  typedef enum logic {SRC_PROX, SRC_AMBIENT} source_e;
endpackage

// file: test/prox_thresh_chk.sv
// Port checker for the threshold interrupt block.
// Assumes binding to the block's top ports.
`timescale 1ns/1ps
module prox_thresh_chk (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Type
  input wire logic hready, // Ready
  input wire logic [31:0] hrdata, // Data
  input wire logic hreadyout, // Ready
  input wire logic hresp, // Resp
  input wire logic prox_valid, // Strobe
  input wire logic als_valid, // Strobe
  input wire logic irq // Irq
);
  logic acc_q, acc2_q, val_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {acc_q, acc2_q, val_q} <= 3'h0;
    else {acc_q, acc2_q, val_q} <= {hsel & hready & htrans[1], acc_q, prox_valid | als_valid};
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RISE: assert property ($rose(irq) |-> val_q)
    else $error("irq rose without a result");
  AST_HOLD: assert property ($fell(irq) |-> acc2_q)
    else $error("irq fell without a bus access");
  AST_RDZ: assert property (!acc_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_RST: assert property ($rose(hresetn) |-> !irq)
    else $error("irq after reset");
  AST_CHG: assert property ($changed(irq) |-> val_q || acc2_q)
    else $error("irq changed without a result or a bus access");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (val_q && !irq);
endmodule // prox_thresh_chk
bind proximity_threshold_interrupt prox_thresh_chk u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hready, .hrdata, .hreadyout, .hresp, .prox_valid, .als_valid, .irq);

// file: test/ahb_host.sv
// Host model issuing single word bus transfers.
// Assumes the slave ready is fed back as hready.
`timescale 1ns/1ps
module ahb_host (
  input wire logic hclk, // Clock
  input wire logic hready, // Ready
  input wire logic [31:0] hrdata, // Data
  output logic hsel = 1'b1, // Select
  output logic [31:0] haddr = 32'h0, // Addr
  output logic [1:0] htrans = 2'h0, // Type
  output logic hwrite = 1'b0, // Write
  output logic [2:0] hsize = 3'h2, // Size
  output logic [31:0] hwdata = 32'h0 // Data
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    q = hrdata;
  endtask
endmodule // ahb_host

// file: test/proximity_threshold_interrupt_bench.sv
// Self-checking bench for the threshold interrupt block.
// Assumes host model and checker are compiled first.
`timescale 1ns/1ps
module proximity_threshold_interrupt_bench;
  import prox_thresh_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, prox_valid = 1'b0, als_valid = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  result_t prox_result = 16'h0, als_result = 16'h0;
  int miscompares = 0, num_checks = 0, cyc = 0, ch, cl, hits, k, st, msk, en, sel, hi;
  int lv = 0, ie, ee;
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  ahb_host u_host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  proximity_threshold_interrupt u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .prox_valid, .prox_result,
    .als_valid, .als_result, .irq);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic result_t pick(input int m);
    result_t v;
    v = 16'($urandom);
    case (m)
      0: pick = v % 16'h2000;
      1: pick = v | 16'hf000;
      2: pick = v[0] ? 16'(hi) : 16'h2000;
      default: pick = v;
    endcase
  endfunction
  // Model updates from the selected channel only, then irq is compared
  task automatic smp(input result_t p, input result_t a);
    result_t v;
    v = sel ? a : p;
    prox_result <= p;
    als_result <= a;
    prox_valid <= 1'b1;
    als_valid <= 1'b1;
    @(posedge hclk);
    prox_valid <= 1'b0;
    als_valid <= 1'b0;
    lv = v;
    if (en) begin
      ch = (v > hi) ? ch + 1 : 0;
      cl = (v < 'h2000) ? cl + 1 : 0;
      st |= (ch == hits) ? 1 : 0;
      st |= (cl == hits) ? 2 : 0;
    end
    @(posedge hclk);
    chk({31'h0, irq}, {31'h0, (st & msk) != 0});
  endtask
  initial begin
    k = $urandom(32'h867997c1);
    st = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(8'h00, 32'h10);
    rdc(8'h04, 32'hffff);
    rdc(8'h10, 32'h3);
    rdc(8'h1c, 32'h0);
    for (int r = 0; r < 6; r++) begin
      sel = r % 2;
      en = (r != 4);
      msk = (r == 3) ? 0 : 3;
      hits = 1 + $urandom % 5;
      hi = (r == 5) ? 'hffff : 'h8000 + $urandom % 256;
      ee = $urandom % 2;
      ie = ee & $urandom % 2;
      chk(ie & ~ee, 32'h0);
      rdc(8'h14, lv);
      rdc(8'h18, ch << 8 | cl);
      u_host.xfer(1'b1, 8'h00, 32'h0, q);
      ch = 0;
      cl = 0;
      rdc(8'h0c, st);
      st = 0;
      u_host.xfer(1'b1, 8'h04, hi, q);
      u_host.xfer(1'b1, 8'h08, 32'h2000, q);
      u_host.xfer(1'b1, 8'h10, msk, q);
      u_host.xfer(1'b1, 8'h00, hits << 4 | sel << 1 | en, q);
      repeat (60) begin
        if ($urandom % 3 == 0) k = $urandom % 4;
        smp(pick(k), pick($urandom % 4));
        repeat ($urandom % 2) @(posedge hclk);
      end
    end
    rdc(8'h14, lv);
    rdc(8'h18, ch << 8 | cl);
    rdc(8'h0c, st);
    end_sim();
  end
endmodule // proximity_threshold_interrupt_bench
